// ---- src/status_divider_defs.svh ----
// Function
// - Input divider, bits 15:12, divides sensor frequency
// - Reference divider bits 9:0 divides device clock
// - Bits 15:14 name latest error source channel
// - Errors latched until status or source read
// - Bit 13 under-range error flag
// - Bit 12 over-range error flag
// - Bit 11 watchdog timeout error flag
// - Bit 10 amplitude-high error flag
// - Bit 9 amplitude-low error flag
// - Bit 8 zero-count error flag
// - Error flags restart after each status read
// - Bits 3..0 show unread results channels 0..3
// - Error and ready flags and interruptOut_n only when routing enabled
`ifndef STATUS_DIVIDER_DEFS_SVH
`define STATUS_DIVIDER_DEFS_SVH
`define OFS_CH3_DIVIDERS 8'h17
`define OFS_STATUS 8'h18
`define OFS_IRQ_STATUS 8'h40
`define OFS_IRQ_ENABLE 8'h41
`define OFS_IRQ_CLEAR 8'h42
`define DIV_RESET 16'h0000
`define DIV_WRITE_MASK 16'hF3FF
`define DIV_FIN_MSB 15
`define DIV_FIN_LSB 12
`define DIV_FREF_MSB 9
`define DIV_FREF_LSB 0
`define ST_CHAN_MSB 15
`define ST_CHAN_LSB 14
`define ST_ERR_MSB 13
`define ST_ERR_LSB 8
`define ST_READY_BIT 6
`define ROUTE_ERR_MSB 7
`define ROUTE_ERR_LSB 2
`define ROUTE_READY_BIT 0
`endif

// ---- src/status_divider_pkg.sv ----
package status_divider_pkg;
    // Error kinds in status-bit order: ur, or, wd, ahe, ale, zc
    typedef struct packed {
        logic [5:0] kind;
        logic [1:0] chan;
    } err_event_t;
    typedef struct packed {
        logic [3:0] valid;
        logic seqMode;
        logic [3:0] activeMask;
    } result_event_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;
endpackage : status_divider_pkg

// ---- src/sensor_status_divider_regs.sv ----
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "status_divider_defs.svh"
module sensor_status_divider_regs
    import status_divider_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // Conversion core
    input wire err_event_t errEvent,
    input wire result_event_t resultEvent,
    input wire logic [7:0] errorRouting,
    input wire logic [3:0] resultRead,
    // Divider settings
    output logic [3:0] sensorInputDivider,
    output logic [9:0] referenceClockDivider,
    // Interrupts
    output logic irq,
    output logic interruptOut_n
);
    // Bus and divider state
    bus_state_t busState_q;
    bus_state_t busState_d;
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic [1:0] errChan_q;
    logic [1:0] errChan_d;
    logic [31:0] rdData_q;

    // Sticky flags, held in the flag cells further down
    logic [5:0] errFlags_q;
    logic ready_q;
    logic [3:0] unread_q;
    logic [2:0] irqStatus_q;

    // Sequence progress and interrupt enables
    logic [3:0] fresh_q;
    logic [3:0] fresh_d;
    logic [2:0] irqEnable_q;
    logic [2:0] irqEnable_d;

    // Bus decode: a request is taken only while no ack is pending
    wire logic access = wbCyc && wbStb && (busState_q == BUS_IDLE);
    wire logic wrLow = access && wbWe && wbSel[0];
    wire logic wrHigh = access && wbWe && wbSel[1];
    wire logic hitDiv = (wbAdr == `OFS_CH3_DIVIDERS);
    wire logic hitStatus = (wbAdr == `OFS_STATUS);
    wire logic hitIrqStatus = (wbAdr == `OFS_IRQ_STATUS);
    wire logic hitIrqEnable = (wbAdr == `OFS_IRQ_ENABLE);
    wire logic hitIrqClear = (wbAdr == `OFS_IRQ_CLEAR);
    // Status is read-only: a write there is acked and dropped
    wire logic rdStatus = access && !wbWe && hitStatus;
    wire logic wrDiv = access && wbWe && hitDiv;
    wire logic wrEnable = wrLow && hitIrqEnable;
    wire logic wrClear = wrLow && hitIrqClear;

    // Divider write, byte lane by byte lane
    wire logic [7:0] divHighByte = wrHigh ? wbDatW[15:8] : div_q[15:8];
    wire logic [7:0] divLowByte = wrLow ? wbDatW[7:0] : div_q[7:0];
    wire logic [15:0] divWrite = {divHighByte, divLowByte};

    // Error routing, one enable per error kind
    wire logic [5:0] errEnable = errorRouting[`ROUTE_ERR_MSB:`ROUTE_ERR_LSB];
    wire logic underRangeRouted = errEvent.kind[5] && errEnable[5];
    wire logic overRangeRouted = errEvent.kind[4] && errEnable[4];
    wire logic watchdogRouted = errEvent.kind[3] && errEnable[3];
    wire logic amplitudeHighRouted = errEvent.kind[2] && errEnable[2];
    wire logic amplitudeLowRouted = errEvent.kind[1] && errEnable[1];
    wire logic zeroCountRouted = errEvent.kind[0] && errEnable[0];
    wire logic [5:0] errRouted = {underRangeRouted, overRangeRouted, watchdogRouted, amplitudeHighRouted,
        amplitudeLowRouted, zeroCountRouted};
    wire logic errAny = |errRouted;
    wire logic readyEnable = errorRouting[`ROUTE_READY_BIT];

    // A result read of the channel named as error source also releases the errors
    wire logic srcRead = resultRead[errChan_q];
    wire logic errRelease = rdStatus || srcRead;
    wire logic [5:0] errClear = errRelease ? 6'h3F : 6'h00;

    // Sequential mode waits until every active channel has a fresh result
    wire logic newResult = |resultEvent.valid;
    wire logic [3:0] freshNext = fresh_q | resultEvent.valid;
    wire logic seqDone = ((freshNext & resultEvent.activeMask) == resultEvent.activeMask) && newResult;
    wire logic singleDone = !resultEvent.seqMode && newResult;
    wire logic readyEvent = readyEnable && (singleDone || (resultEvent.seqMode && seqDone));

    // Status fields, one named wire each
    wire logic [1:0] errorSourceChannel = errChan_q;
    wire logic underRangeFlag = errFlags_q[5];
    wire logic overRangeFlag = errFlags_q[4];
    wire logic watchdogTimeoutFlag = errFlags_q[3];
    wire logic amplitudeHighFlag = errFlags_q[2];
    wire logic amplitudeLowFlag = errFlags_q[1];
    wire logic zeroCountFlag = errFlags_q[0];
    wire logic resultReadyFlag = ready_q;
    wire logic unreadResultFlagCh0 = unread_q[0];
    wire logic unreadResultFlagCh1 = unread_q[1];
    wire logic unreadResultFlagCh2 = unread_q[2];
    wire logic unreadResultFlagCh3 = unread_q[3];
    wire logic [5:0] errorFlags = {underRangeFlag, overRangeFlag, watchdogTimeoutFlag, amplitudeHighFlag,
        amplitudeLowFlag, zeroCountFlag};
    // Channel 0 sits in the highest unread bit
    wire logic [3:0] unreadFlags = {unreadResultFlagCh0, unreadResultFlagCh1, unreadResultFlagCh2,
        unreadResultFlagCh3};
    // Unused status bits read zero
    wire logic [15:0] statusWord = {errorSourceChannel, errorFlags, 1'b0, resultReadyFlag, 2'b00, unreadFlags};

    // Read selection: unmapped words read zero
    wire logic [31:0] rdDiv = hitDiv ? {16'h0000, div_q} : 32'h00000000;
    wire logic [31:0] rdStatusWord = hitStatus ? {16'h0000, statusWord} : 32'h00000000;
    wire logic [31:0] rdIrqStatus = hitIrqStatus ? {29'h0000000, irqStatus_q} : 32'h00000000;
    wire logic [31:0] rdIrqEnable = hitIrqEnable ? {29'h0000000, irqEnable_q} : 32'h00000000;
    wire logic [31:0] rdMux = rdDiv | rdStatusWord | rdIrqStatus | rdIrqEnable;

    // Interrupt events: bit 0 error, bit 1 ready, bit 2 new result
    wire logic irqErrorEvent = errAny;
    wire logic irqReadyEvent = readyEvent;
    wire logic irqResultEvent = newResult;
    wire logic [2:0] irqEvents = {irqResultEvent, irqReadyEvent, irqErrorEvent};
    wire logic [2:0] irqClear = wrClear ? wbDatW[2:0] : 3'h0;

    // Divider fields as the core sees them
    wire logic [3:0] inputDividerField = div_q[`DIV_FIN_MSB:`DIV_FIN_LSB];
    wire logic [9:0] referenceDividerField = div_q[`DIV_FREF_MSB:`DIV_FREF_LSB];

    // Ack lasts one cycle even when the master keeps its strobe up
    always_comb
    begin
        busState_d = BUS_IDLE;
        case (busState_q)
            BUS_IDLE:
            begin
                if (wbCyc && wbStb)
                    busState_d = BUS_ACK;
            end
            BUS_ACK:
                busState_d = BUS_IDLE;
            default:
                busState_d = BUS_IDLE;
        endcase
    end

    assign div_d = wrDiv ? divWrite : div_q;
    assign errChan_d = errAny ? errEvent.chan : errChan_q;
    assign irqEnable_d = wrEnable ? wbDatW[2:0] : irqEnable_q;
    // Fresh set only builds up inside an unfinished sequence
    assign fresh_d = (resultEvent.seqMode && !seqDone) ? freshNext : 4'h0;

    // Bus state
    always_ff @(posedge clk)
    begin
        if (rst)
            busState_q <= BUS_IDLE;
        else
            busState_q <= busState_d;
    end

    // Read data is captured every cycle and used only while ack stands
    always_ff @(posedge clk)
    begin
        if (rst)
            rdData_q <= 32'h00000000;
        else
            rdData_q <= rdMux;
    end

    // Reserved bits 11:10 are stored as written; host keeps them zero
    always_ff @(posedge clk)
    begin
        if (rst)
            div_q <= `DIV_RESET;
        else
            div_q <= div_d;
    end

    // Error source channel follows the latest routed error
    always_ff @(posedge clk)
    begin
        if (rst)
            errChan_q <= 2'h0;
        else
            errChan_q <= errChan_d;
    end

    // Sequence progress
    always_ff @(posedge clk)
    begin
        if (rst)
            fresh_q <= 4'h0;
        else
            fresh_q <= fresh_d;
    end

    // Interrupt enables
    always_ff @(posedge clk)
    begin
        if (rst)
            irqEnable_q <= 3'h0;
        else
            irqEnable_q <= irqEnable_d;
    end

    // Set wins over the release so a same-cycle error is never lost
    sticky_bits #(
        .WIDTH(6)
    ) errorFlagBits (
        .clk(clk),
        .rst(rst),
        .set(errRouted),
        .clear(errClear),
        .flags(errFlags_q)
    );

    // Status read drops the ready flag unless a new one arrives with it
    sticky_bits #(
        .WIDTH(1)
    ) readyFlagBit (
        .clk(clk),
        .rst(rst),
        .set(readyEvent),
        .clear(rdStatus),
        .flags(ready_q)
    );

    // Unread flags: a new result in the cycle of its read keeps the flag up
    sticky_bits #(
        .WIDTH(4)
    ) unreadFlagBits (
        .clk(clk),
        .rst(rst),
        .set(resultEvent.valid),
        .clear(resultRead),
        .flags(unread_q)
    );

    // Interrupt status: a clear write loses to an event in the same cycle
    sticky_bits #(
        .WIDTH(3)
    ) irqStatusBits (
        .clk(clk),
        .rst(rst),
        .set(irqEvents),
        .clear(irqClear),
        .flags(irqStatus_q)
    );

    // Outputs
    assign wbAck = (busState_q == BUS_ACK);
    assign wbDatR = rdData_q;
    assign sensorInputDivider = inputDividerField;
    assign referenceClockDivider = referenceDividerField;
    assign irq = |(irqStatus_q & irqEnable_q);
    // Pin follows the routed status flags, active low
    assign interruptOut_n = !((|errFlags_q) || ready_q);
endmodule : sensor_status_divider_regs

// Sticky flag cells: set wins over clear, so no event is lost
module sticky_bits #(
    parameter int WIDTH = 1
)
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Events and clears
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    // Flags
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_q;
    wire logic [WIDTH-1:0] flags_d = (flags_q & ~clear) | set;

    always_ff @(posedge clk)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    assign flags = flags_q;
endmodule : sticky_bits
`default_nettype wire

// ---- tb/ssd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssd_checker
    import status_divider_pkg::*;
(
    // Watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [31:0] wbDatW,
    input wire logic wbAck,
    input wire err_event_t errEvent,
    input wire result_event_t resultEvent,
    input wire logic [7:0] errorRouting,
    input wire logic [3:0] resultRead,
    input wire logic [3:0] sensorInputDivider,
    input wire logic [9:0] referenceClockDivider,
    input wire logic interruptOut_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic routed = (errEvent.kind & errorRouting[7:2]) != 6'h0;
    wire logic stRead = wbStb && !wbAck && !wbWe && wbAdr == 8'h18;
    wire logic rdyEv = errorRouting[0] && resultEvent.valid != 4'h0;
    sequence s_take; wbStb && !wbAck; endsequence
    sequence s_div; s_take ##0 wbWe && wbAdr == 8'h17; endsequence
    property p_ack; s_take |=> wbAck ##1 !wbAck; endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_fin; s_div |=> sensorInputDivider == $past(wbDatW[15:12]); endproperty
    a_fin: assert property (p_fin) else $error("bad input divider");
    property p_ref; s_div |=> referenceClockDivider == $past(wbDatW[9:0]); endproperty
    a_ref: assert property (p_ref) else $error("bad reference divider");
    property p_err; routed |=> !interruptOut_n; endproperty
    a_err: assert property (p_err) else $error("routed error lost");
    property p_quiet; interruptOut_n && !routed && !rdyEv |=> interruptOut_n; endproperty
    a_quiet: assert property (p_quiet) else $error("unrouted flag");
    property p_hold; !interruptOut_n && !stRead && resultRead == 4'h0 |=> !interruptOut_n; endproperty
    a_hold: assert property (p_hold) else $error("flag not held");
    property p_clr; stRead && errEvent.kind == 6'h0 && resultEvent.valid == 4'h0 |=> interruptOut_n; endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared");
    property p_rdy; rdyEv && !resultEvent.seqMode |=> !interruptOut_n; endproperty
    a_rdy: assert property (p_rdy) else $error("ready missed");
endmodule : ssd_checker
`default_nettype wire

// ---- tb/conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module conv_model
    import status_divider_pkg::*;
(
    // Conversion side
    input wire logic clk,
    output err_event_t errEvent,
    output result_event_t resultEvent,
    output logic [3:0] resultRead
);
    initial {errEvent, resultEvent, resultRead} = '0;
    // Mode levels stay put between pulses
    task automatic pulse(input err_event_t e, input result_event_t r, input logic [3:0] h);
        @(posedge clk);
        {errEvent, resultEvent, resultRead} <= {e, r, h};
        @(posedge clk);
        {errEvent, resultEvent.valid, resultRead} <= '0;
        @(posedge clk);
    endtask : pulse
endmodule : conv_model
`default_nettype wire

// ---- tb/sensor_status_divider_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) if ((a) !== (b)) begin fails++; $display("unexpected %0t %h %h", $time, a, b); end checksDone++;
module sensor_status_divider_regs_tb
    import status_divider_pkg::*;
;
    logic clk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, irq, interruptOut_n;
    logic [7:0] wbAdr = 0, errorRouting = 0;
    logic [31:0] wbDatW = 0, wbDatR, rd;
    logic [3:0] sensorInputDivider, resultRead;
    logic [9:0] referenceClockDivider;
    err_event_t errEvent;
    result_event_t resultEvent;
    int fails = 0, checksDone = 0, ticks = 0;
    conv_model m (.clk, .errEvent, .resultEvent, .resultRead);
    sensor_status_divider_regs dut (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel(4'hF), .wbDatW, .wbDatR,
        .wbAck, .errEvent, .resultEvent, .errorRouting, .resultRead, .sensorInputDivider, .referenceClockDivider,
        .irq, .interruptOut_n);
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        ticks++;
        if (ticks == 3000)
        begin
            fails++;
            results();
        end
    end
    task automatic results();
        if (fails == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, w, a, d};
        do @(posedge clk); while (wbAck !== 1'b1);
        rd = wbDatR;
        {wbCyc, wbStb} <= 2'h0;
        @(posedge clk);
    endtask : wb
    task automatic t_div();
        wb(0, 8'h17, 0);
        `CHK(rd, 32'h0)
        wb(1, 8'h17, 32'h5123);
        `CHK({sensorInputDivider, referenceClockDivider}, 14'h1523)
        wb(0, 8'h17, 0);
        `CHK(rd, 32'h5123)
        wb(0, 8'h55, 0);
        `CHK(rd, 32'h0)
    endtask : t_div
    task automatic t_err();
        errorRouting <= 8'hFD;
        for (int i = 0; i < 6; i++)
        begin
            m.pulse({6'(1 << i), 2'(i)}, 9'h0, 0);
            `CHK(interruptOut_n, 1'b0)
            wb(0, 8'h18, 0);
            `CHK(rd[15:8], {2'(i), 6'(1 << i)})
            wb(0, 8'h18, 0);
            `CHK(rd[13:8], 6'h0)
        end
        m.pulse({6'h20, 2'h2}, 9'h0, 0);
        m.pulse(0, 9'h0, 4'h4);
        `CHK(interruptOut_n, 1'b1)
        errorRouting <= 8'h00;
        m.pulse({6'h3F, 2'h3}, 9'h0, 0);
        `CHK(interruptOut_n, 1'b1)
    endtask : t_err
    task automatic t_ready();
        errorRouting <= 8'h01;
        m.pulse(0, {4'h2, 5'h0}, 0);
        wb(0, 8'h18, 0);
        `CHK({rd[6], rd[3:0]}, 5'h14)
        m.pulse(0, {4'h1, 5'h19}, 0);
        wb(0, 8'h18, 0);
        `CHK(rd[6], 1'b0)
        m.pulse(0, {4'h8, 5'h19}, 0);
        wb(0, 8'h18, 0);
        `CHK({rd[6], rd[3:0]}, 5'h1D)
        m.pulse(0, 9'h0, 4'hB);
        wb(0, 8'h18, 0);
        `CHK(rd[3:0], 4'h0)
    endtask : t_ready
    task automatic t_irq();
        errorRouting <= 8'h80;
        wb(1, 8'h41, 1);
        m.pulse({6'h20, 2'h0}, 9'h0, 0);
        @(posedge clk);
        `CHK(irq, 1'b1)
        wb(1, 8'h42, 1);
        `CHK(irq, 1'b0)
        wb(1, 8'h41, 0);
        m.pulse({6'h20, 2'h0}, 9'h0, 0);
        @(posedge clk);
        `CHK(irq, 1'b0)
    endtask : t_irq
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_div();
        t_err();
        t_ready();
        t_irq();
        results();
    end
endmodule : sensor_status_divider_regs_tb
bind sensor_status_divider_regs ssd_checker chk (.clk, .rst, .wbStb, .wbWe, .wbAdr, .wbDatW, .wbAck, .errEvent,
    .resultEvent, .errorRouting, .resultRead, .sensorInputDivider, .referenceClockDivider, .interruptOut_n);
`default_nettype wire
